/* File: verilog/scfp_serial_config_flash_port.sv */
// Serial slave port of a configuration flash with arming logic
`timescale 1ns/1ns
module scfp_serial_config_flash_port #(
   parameter int unsigned MEM_BITS = scfp_pkg::CAP_SMALL_BITS
) (
   // Reference clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // Serial link
   input wire logic i_serial_clock_in,
   input wire logic i_chip_select_low_n,
   input wire logic i_serial_data_in,
   output logic o_serial_data_out,
   output logic o_serial_data_out_oe_n,
   // Status
   output logic o_armed
);
   import scfp_pkg::*;

   // Only the two documented sizes are meant to be used
   localparam int unsigned DEPTH = MEM_BITS / BYTE_BITS;
   localparam int unsigned AW = $clog2(DEPTH);

   // ==========================================================
   // Reference domain: arming on the first select fall
   logic cs_meta_r;
   logic cs_sync_r;
   logic cs_prev_r;
   logic armed_r;
   logic link_clr_r;
   wire cs_fall = cs_prev_r & ~cs_sync_r;

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         cs_meta_r <= 1'b0;
         cs_sync_r <= 1'b0;
         cs_prev_r <= 1'b0;
         armed_r <= ARMED_RST;
         link_clr_r <= 1'b1;
      end else begin
         cs_meta_r <= i_chip_select_low_n;
         cs_sync_r <= cs_meta_r;
         cs_prev_r <= cs_sync_r;
         // Select low at reset release does not count as a fall
         if (cs_fall) begin
            armed_r <= 1'b1;
         end
         link_clr_r <= 1'b0;
      end
   end

   assign o_armed = armed_r;

   // ==========================================================
   // Link domain: arming level brought onto the serial clock
   logic arm_meta_r;
   logic arm_sync_r;

   // Limitation: clear lifts on the reference clock, serial clock must idle
   always_ff @(posedge i_serial_clock_in or posedge link_clr_r) begin
      if (link_clr_r) begin
         arm_meta_r <= ARMED_RST;
         arm_sync_r <= ARMED_RST;
      end else begin
         arm_meta_r <= armed_r;
         arm_sync_r <= arm_meta_r;
      end
   end

   // ==========================================================
   // Link domain: frame decoder
   scfp_state_e state_r;
   scfp_state_e state_nxt;
   logic [4:0] cnt_r;
   logic [4:0] cnt_nxt;
   logic [7:0] shift_r;
   logic [7:0] shift_nxt;
   logic [23:0] addr_r;
   logic [23:0] addr_nxt;
   logic [2:0] idx_r;
   logic [2:0] idx_nxt;
   logic prog_r;
   logic prog_nxt;
   logic rd_en;
   logic [AW-1:0] rd_addr;
   logic wr_en;
   logic [7:0] rd_data;

   wire [7:0] shift_in = {shift_r[6:0], i_serial_data_in};
   wire [23:0] addr_in = {addr_r[22:0], i_serial_data_in};
   wire [23:0] addr_inc = addr_r + ADDR_STEP;
   wire opc_known = (shift_in == OPC_READ) || (shift_in == OPC_PROGRAM);
   wire idx_done = (idx_r == BIT_LSB);
   wire [2:0] idx_dec = idx_r - 3'h1;
   wire [4:0] cnt_inc = cnt_r + 5'h01;
   wire opc_done = (cnt_r == OPC_LAST_BIT);
   wire addr_done = (cnt_r == ADDR_LAST_BIT);
   wire opc_prog = (shift_in == OPC_PROGRAM);
   wire read_phase = (state_r == SCFP_READ);
   // Bit for the next falling edge, picked from the fetched byte
   wire dout_bit = rd_data[idx_r];

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      shift_nxt = shift_r;
      addr_nxt = addr_r;
      idx_nxt = idx_r;
      prog_nxt = prog_r;
      rd_en = 1'b0;
      rd_addr = addr_r[AW-1:0];
      wr_en = 1'b0;
      case (state_r)
         SCFP_OPCODE: begin
            shift_nxt = shift_in;
            cnt_nxt = cnt_inc;
            // Frame running while arming settles is never served
            if (!arm_sync_r) begin
               state_nxt = SCFP_IGNORE;
            end else if (opc_done) begin
               cnt_nxt = CNT_RST;
               prog_nxt = opc_prog;
               state_nxt = opc_known ? SCFP_ADDR : SCFP_IGNORE;
            end
         end
         SCFP_ADDR: begin
            addr_nxt = addr_in;
            cnt_nxt = cnt_inc;
            if (addr_done) begin
               idx_nxt = BIT_MSB;
               rd_en = ~prog_r;
               rd_addr = addr_in[AW-1:0];
               state_nxt = prog_r ? SCFP_PROG : SCFP_READ;
            end
         end
         SCFP_READ: begin
            idx_nxt = idx_dec;
            if (idx_done) begin
               // Next byte fetched one edge ahead of its first bit
               rd_en = 1'b1;
               rd_addr = addr_inc[AW-1:0];
               addr_nxt = addr_inc;
               idx_nxt = BIT_MSB;
            end
         end
         SCFP_PROG: begin
            shift_nxt = shift_in;
            idx_nxt = idx_dec;
            if (idx_done) begin
               wr_en = 1'b1;
               addr_nxt = addr_inc;
               idx_nxt = BIT_MSB;
            end
         end
         default: begin
            state_nxt = SCFP_IGNORE;
         end
      endcase
   end

   // Select high clears the frame, so a data byte cut short is never programmed
   always_ff @(posedge i_serial_clock_in or posedge i_chip_select_low_n) begin
      if (i_chip_select_low_n) begin
         state_r <= SCFP_OPCODE;
         cnt_r <= CNT_RST;
         shift_r <= SHIFT_RST;
         addr_r <= ADDR_RST;
         idx_r <= BIT_MSB;
         prog_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         shift_r <= shift_nxt;
         addr_r <= addr_nxt;
         idx_r <= idx_nxt;
         prog_r <= prog_nxt;
      end
   end

   scfp_mem #(
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_mem (
      .i_clk(i_serial_clock_in),
      .i_rd_en(rd_en),
      .i_rd_addr(rd_addr),
      .o_rd_data(rd_data),
      .i_wr_en(wr_en),
      .i_wr_addr(addr_r[AW-1:0]),
      .i_wr_data(shift_in)
   );

   // ==========================================================
   // Link domain: output driver on the falling edge
   // Select rise releases the pin at once, with no clock needed
   always_ff @(negedge i_serial_clock_in or posedge i_chip_select_low_n) begin
      if (i_chip_select_low_n) begin
         o_serial_data_out <= DOUT_RST;
         o_serial_data_out_oe_n <= OE_N_RST;
      end else if (read_phase) begin
         o_serial_data_out <= dout_bit;
         o_serial_data_out_oe_n <= 1'b0;
      end else begin
         o_serial_data_out_oe_n <= OE_N_RST;
      end
   end

endmodule : scfp_serial_config_flash_port

/* File: verilog/scfp_pkg.sv */
// Shared constants and types of the serial configuration flash port
package scfp_pkg;

   // ==========================================================
   // Capacity choices, in bits
   localparam int unsigned CAP_SMALL_BITS = 1048576;
   localparam int unsigned CAP_LARGE_BITS = 4194304;
   localparam int unsigned BYTE_BITS = 8;

   // ==========================================================
   // Instruction codes and frame field positions
   localparam logic [7:0] OPC_READ = 8'h03;
   localparam logic [7:0] OPC_PROGRAM = 8'h02;
   localparam logic [4:0] OPC_LAST_BIT = 5'h07;
   localparam logic [4:0] ADDR_LAST_BIT = 5'h17;
   localparam logic [4:0] CNT_RST = 5'h00;
   localparam logic [2:0] BIT_MSB = 3'h7;
   localparam logic [2:0] BIT_LSB = 3'h0;
   localparam logic [23:0] ADDR_STEP = 24'h000001;

   // ==========================================================
   // Values after reset, and of the erased array
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] SHIFT_RST = 8'h00;
   localparam logic [23:0] ADDR_RST = 24'h000000;
   localparam logic ARMED_RST = 1'b0;
   localparam logic DOUT_RST = 1'b0;
   localparam logic OE_N_RST = 1'b1;

   // ==========================================================
   // Frame states on the serial clock
   typedef enum logic [2:0] {
      SCFP_OPCODE,
      SCFP_ADDR,
      SCFP_READ,
      SCFP_PROG,
      SCFP_IGNORE
   } scfp_state_e;

endpackage : scfp_pkg

/* File: verilog/scfp_mem.sv */
// Byte-wide flash array with registered read data, on the serial clock
`timescale 1ns/1ns
module scfp_mem #(
   parameter int unsigned DEPTH = 131072,
   parameter int unsigned AW = 17
) (
   // Clock
   input wire logic i_clk,
   // Read port
   input wire logic i_rd_en,
   input wire logic [AW-1:0] i_rd_addr,
   output logic [7:0] o_rd_data,
   // Program port
   input wire logic i_wr_en,
   input wire logic [AW-1:0] i_wr_addr,
   input wire logic [7:0] i_wr_data
);
   import scfp_pkg::*;

   logic [7:0] mem [DEPTH];

   // ==========================================================
   // Delivered erased
   initial begin
      for (int i = 0; i < DEPTH; i++) begin
         mem[i] = ERASED_BYTE;
      end
   end

   // ==========================================================
   // Access
   // Programming only clears bits; without erase a bit never returns to 1
   // Plain always, since the erased preset also writes the array
   always @(posedge i_clk) begin
      if (i_wr_en) begin
         mem[i_wr_addr] <= mem[i_wr_addr] & i_wr_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rd_en) begin
         o_rd_data <= mem[i_rd_addr];
      end
   end

endmodule : scfp_mem

/* File: sim/scfp_port_monitor.sv */
// Pin checks of the serial configuration flash port
`timescale 1ns/1ns
module scfp_port_monitor (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_serial_clock_in,
   input wire logic i_chip_select_low_n,
   input wire logic i_serial_data_in,
   input wire logic o_serial_data_out,
   input wire logic o_serial_data_out_oe_n,
   input wire logic o_armed
);
   logic [5:0] rise_cnt_r;
   // ==========
   // Rising serial edges since select fell
   always_ff @(posedge i_serial_clock_in or posedge i_chip_select_low_n) begin
      if (i_chip_select_low_n) rise_cnt_r <= 6'h00;
      else if (rise_cnt_r != 6'h3F) rise_cnt_r <= rise_cnt_r + 6'h01;
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   sequence s_first_fall;
      $fell(i_chip_select_low_n) && !o_armed;
   endsequence
   sequence s_data_moved;
      $changed(o_serial_data_out) && !i_chip_select_low_n;
   endsequence
   sequence s_oe_rise;
      $rose(o_serial_data_out_oe_n);
   endsequence
   sequence s_oe_fall;
      $fell(o_serial_data_out_oe_n);
   endsequence
   a_desel_hiz: assert property (i_chip_select_low_n |-> o_serial_data_out_oe_n)
      else $error("pin driven while deselected");
   a_desel_zero: assert property (i_chip_select_low_n |-> !o_serial_data_out)
      else $error("data not cleared while deselected");
   a_out_on_fall: assert property (s_data_moved |-> !i_serial_clock_in)
      else $error("data moved off falling edge");
   a_arm_rise: assert property (s_first_fall |-> ##[1:5] o_armed)
      else $error("select fall did not arm");
   a_arm_holds: assert property (o_armed |=> o_armed)
      else $error("armed dropped");
   a_unarmed_quiet: assert property (!o_armed |-> o_serial_data_out_oe_n)
      else $error("output before arming");
   a_oe_release: assert property (s_oe_rise |-> i_chip_select_low_n)
      else $error("driver released mid frame");
   a_read_turn: assert property (s_oe_fall |-> rise_cnt_r == 6'h20)
      else $error("read data at wrong edge");
endmodule : scfp_port_monitor
bind scfp_serial_config_flash_port scfp_port_monitor u_scfp_port_monitor (
   .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_serial_clock_in(i_serial_clock_in),
   .i_chip_select_low_n(i_chip_select_low_n), .i_serial_data_in(i_serial_data_in),
   .o_serial_data_out(o_serial_data_out), .o_serial_data_out_oe_n(o_serial_data_out_oe_n),
   .o_armed(o_armed));

/* File: sim/scfp_master_model.sv */
// Configuration master model on the serial link
`timescale 1ns/1ns
module scfp_master_model (
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_sdi,
   input wire logic i_sdo,
   input wire logic i_oe_n
);
   // Clock stands still low outside frames
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_sdi = 1'b0;
   end
   // Odd lead keeps link phase drifting against the reference
   task automatic open_frame();
      #37 o_cs_n = 1'b0;
      #80;
   endtask : open_frame
   task automatic close_frame();
      #80 o_cs_n = 1'b1;
      o_sdi = ~o_sdi;
      #160;
   endtask : close_frame
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         o_sdi = tx[i];
         #80 o_sclk = 1'b1;
         rx[i] = (i_oe_n === 1'b0) ? i_sdo : 1'bx;
         #80 o_sclk = 1'b0;
      end
   endtask : xfer
   // Only the upper four bits, so the frame can be cut mid byte
   task automatic cut_byte(input logic [7:0] tx);
      for (int i = 7; i >= 4; i--) begin
         o_sdi = tx[i];
         #80 o_sclk = 1'b1;
         #80 o_sclk = 1'b0;
      end
   endtask : cut_byte
endmodule : scfp_master_model

/* File: sim/scfp_serial_config_flash_port_tb.sv */
// Self-checking bench of the serial configuration flash port
`timescale 1ns/1ns
module scfp_serial_config_flash_port_tb;
   import scfp_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_rst = 1'b1;
   logic sclk, cs_n, sdi, sdo, oe_n, armed;
   int err_total = 0;
   int checked = 0;
   int cycles = 0;
   logic [7:0] rd;
   always #20 i_ref_clk = ~i_ref_clk;
   scfp_serial_config_flash_port #(.MEM_BITS(CAP_SMALL_BITS)) u_scfp_serial_config_flash_port (
      .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_serial_clock_in(sclk),
      .i_chip_select_low_n(cs_n), .i_serial_data_in(sdi), .o_serial_data_out(sdo),
      .o_serial_data_out_oe_n(oe_n), .o_armed(armed));
   scfp_master_model u_scfp_master_model (
      .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo), .i_oe_n(oe_n));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic final_report();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : final_report
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 8000) begin
         err_total++;
         final_report();
      end
   end
   task automatic cmd(input logic [7:0] op, input logic [23:0] addr);
      u_scfp_master_model.open_frame();
      u_scfp_master_model.xfer(op, rd);
      u_scfp_master_model.xfer(addr[23:16], rd);
      u_scfp_master_model.xfer(addr[15:8], rd);
      u_scfp_master_model.xfer(addr[7:0], rd);
   endtask : cmd
   task automatic read_expect(input logic [23:0] addr, input logic [7:0] exp);
      cmd(OPC_READ, addr);
      u_scfp_master_model.xfer(8'h00, rd);
      check("read byte", rd, exp);
      check("driving", {7'h00, oe_n}, 8'h00);
      u_scfp_master_model.close_frame();
      check("released", {6'h00, oe_n, sdo}, 8'h02);
   endtask : read_expect
   task automatic t_arm();
      #2 check("armed early", {7'h00, armed}, 8'h00);
      cmd(OPC_READ, 24'h000000);
      u_scfp_master_model.xfer(8'h00, rd);
      check("arming frame quiet", {7'h00, oe_n}, 8'h01);
      u_scfp_master_model.close_frame();
      check("armed", {7'h00, armed}, 8'h01);
   endtask : t_arm
   task automatic t_program();
      cmd(OPC_PROGRAM, 24'h000020);
      u_scfp_master_model.xfer(8'hA5, rd);
      u_scfp_master_model.xfer(8'h3C, rd);
      u_scfp_master_model.close_frame();
      // Second pass may only clear bits
      cmd(OPC_PROGRAM, 24'h000021);
      u_scfp_master_model.xfer(8'h0F, rd);
      u_scfp_master_model.close_frame();
      read_expect(24'h00001F, ERASED_BYTE);
      read_expect(24'h000020, 8'hA5);
      read_expect(24'h000021, 8'h0C);
      read_expect(24'h020020, 8'hA5);
   endtask : t_program
   task automatic t_stream();
      cmd(OPC_READ, 24'h000020);
      u_scfp_master_model.xfer(8'h00, rd);
      check("stream byte 0", rd, 8'hA5);
      u_scfp_master_model.xfer(8'h00, rd);
      check("stream byte 1", rd, 8'h0C);
      u_scfp_master_model.close_frame();
   endtask : t_stream
   task automatic t_abort();
      u_scfp_master_model.open_frame();
      u_scfp_master_model.xfer(OPC_PROGRAM, rd);
      u_scfp_master_model.xfer(8'h00, rd);
      u_scfp_master_model.close_frame();
      read_expect(24'h000020, 8'hA5);
      // Program byte cut after four bits must not land
      cmd(OPC_PROGRAM, 24'h000030);
      u_scfp_master_model.cut_byte(8'h00);
      u_scfp_master_model.close_frame();
      read_expect(24'h000030, ERASED_BYTE);
   endtask : t_abort
   task automatic t_unknown();
      cmd(8'h5A, 24'h000020);
      u_scfp_master_model.xfer(8'h00, rd);
      check("unknown quiet", {7'h00, oe_n}, 8'h01);
      u_scfp_master_model.close_frame();
      read_expect(24'h000020, 8'hA5);
   endtask : t_unknown
   task automatic t_rearm();
      @(posedge i_ref_clk);
      #2 i_rst = 1'b1;
      repeat (4) @(posedge i_ref_clk);
      #2 i_rst = 1'b0;
      repeat (2) @(posedge i_ref_clk);
      t_arm();
      read_expect(24'h000021, 8'h0C);
   endtask : t_rearm
   initial begin
      repeat (20) @(posedge i_ref_clk);
      #2 i_rst = 1'b0;
      repeat (2) @(posedge i_ref_clk);
      t_arm();
      t_program();
      t_stream();
      t_abort();
      t_unknown();
      t_rearm();
      final_report();
   end
endmodule : scfp_serial_config_flash_port_tb
